// ===== design/self_program_flash_control.sv
// Design decisions made here: the address map and the APB register port.
`timescale 1ns/1ns
`include "self_program_flash_map.svh"

module self_program_flash_control
(
	// Clock, reset and clock enable.
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        clk_en,
	// APB register port.
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// Processor core side.
	input  wire logic        store_program_instr,
	input  wire logic        load_program_instr,
	input  wire logic [15:0] address_pointer,
	input  wire logic [7:0]  data_low_register,
	input  wire logic [7:0]  data_high_register,
	input  wire logic        pc_in_boot,
	input  wire logic        irq_vectors_in_boot,
	input  wire logic        global_irq_enable,
	output logic             load_result_valid,
	output logic      [7:0]  load_result_data,
	output logic             cpu_halt,
	output logic             store_ready_irq,
	output logic             app_read_deny,
	output logic             boot_read_deny,
	output logic             app_irq_block,
	output logic             boot_irq_block,
	// Nonvolatile lock and fuse bytes.
	input  wire logic [7:0]  lock_bits,
	input  wire logic [7:0]  fuse_low_bits,
	input  wire logic [6:0]  boot_start_page,
	output logic             lock_prog_valid,
	output logic      [7:0]  lock_prog_data,
	output logic             ext_prog_block,
	output logic             ext_verify_block,
	output logic             fuse_locked,
	output logic             boot_lock_locked,
	// Flash array side.
	input  wire logic        flash_done,
	output logic             buf_wr_en,
	output logic      [5:0]  buf_wr_word,
	output logic      [15:0] buf_wr_data,
	output logic             buf_discard,
	output logic             page_erase_start,
	output logic             page_write_start,
	output logic      [6:0]  flash_page,
	output logic             rww_read_block
);

	// Decodes the low five control bits into a command.
	function automatic self_program_flash_pkg::cmd_t decode_cmd(input logic [4:0] bits);
		case (bits)
			`CMD_CODE_FILL:  decode_cmd = self_program_flash_pkg::CMD_FILL;
			`CMD_CODE_ERASE: decode_cmd = self_program_flash_pkg::CMD_ERASE;
			`CMD_CODE_WRITE: decode_cmd = self_program_flash_pkg::CMD_WRITE;
			`CMD_CODE_LOCK:  decode_cmd = self_program_flash_pkg::CMD_LOCK;
			`CMD_CODE_RWW:   decode_cmd = self_program_flash_pkg::CMD_RWW;
			default:         decode_cmd = self_program_flash_pkg::CMD_NONE;
		endcase
	endfunction : decode_cmd

	// Tells whether a page lies in the boot loader section.
	function automatic logic page_in_boot(input logic [6:0] page, input logic [6:0] start);
		page_in_boot = (page >= start);
	endfunction : page_in_boot

	self_program_flash_pkg::state_t state_r;
	self_program_flash_pkg::cmd_t   cmd_r;
	self_program_flash_pkg::cmd_t   cmd_w;
	logic [2:0] store_win_r;
	logic [1:0] load_win_r;
	logic       rww_busy_r;
	logic       buf_dirty_r;
	logic       irq_en_r;
	logic       rejected_r;
	logic       halt_r;
	logic       store_en;
	logic       wr_csr;
	logic       wr_status;
	logic       arm;
	logic       spm_take;
	logic       load_take;
	logic [6:0] z_page;
	logic       z_boot;
	logic       write_locked;
	logic [7:0] csr_view;
	logic       mapped;

	assign z_page   = address_pointer[13:7];
	assign z_boot   = page_in_boot(z_page, boot_start_page);
	assign store_en = (state_r != self_program_flash_pkg::ST_IDLE);
	assign mapped   = (paddr == `CSR_OFFSET) || (paddr == `STATUS_OFFSET);
	assign wr_csr   = clk_en && psel && penable && pwrite && (paddr == `CSR_OFFSET);
	assign wr_status = clk_en && psel && penable && pwrite && (paddr == `STATUS_OFFSET);
	assign cmd_w    = decode_cmd(pwdata[4:0]);
	// Commands are only taken while no earlier one is armed or running.
	assign arm      = wr_csr && (cmd_w != self_program_flash_pkg::CMD_NONE) && !store_en;
	assign spm_take = clk_en && store_program_instr
		&& (state_r == self_program_flash_pkg::ST_ARMED);
	assign load_take = clk_en && load_program_instr && (load_win_r != 2'h0);
	assign write_locked = z_boot ? !lock_bits[`LOCK_BOOT_LO]
		: !lock_bits[`LOCK_APP_LO];

	// Command state, store window and the armed command.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			state_r     <= self_program_flash_pkg::ST_IDLE;
			cmd_r       <= self_program_flash_pkg::CMD_NONE;
			store_win_r <= 3'h0;
		end
		else if (clk_en)
		begin
			case (state_r)
				self_program_flash_pkg::ST_IDLE:
				begin
					if (arm)
					begin
						state_r     <= self_program_flash_pkg::ST_ARMED;
						cmd_r       <= cmd_w;
						store_win_r <= `STORE_WINDOW;
					end
				end
				self_program_flash_pkg::ST_ARMED:
				begin
					if (store_program_instr)
					begin
						if ((cmd_r == self_program_flash_pkg::CMD_ERASE
							|| cmd_r == self_program_flash_pkg::CMD_WRITE) && !write_locked)
						begin
							state_r <= self_program_flash_pkg::ST_BUSY;
						end
						else
						begin
							state_r <= self_program_flash_pkg::ST_IDLE;
							cmd_r   <= self_program_flash_pkg::CMD_NONE;
						end
					end
					else if (store_win_r == 3'h1)
					begin
						state_r <= self_program_flash_pkg::ST_IDLE;
						cmd_r   <= self_program_flash_pkg::CMD_NONE;
					end
					else
					begin
						store_win_r <= store_win_r - 3'h1;
					end
				end
				self_program_flash_pkg::ST_BUSY:
				begin
					if (flash_done)
					begin
						state_r <= self_program_flash_pkg::ST_IDLE;
						cmd_r   <= self_program_flash_pkg::CMD_NONE;
					end
				end
				default:
				begin
					state_r <= self_program_flash_pkg::ST_IDLE;
					cmd_r   <= self_program_flash_pkg::CMD_NONE;
				end
			endcase
		end
	end

	// Window in which a load reads the lock or fuse byte.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			load_win_r <= 2'h0;
		else if (clk_en)
		begin
			if (arm && cmd_w == self_program_flash_pkg::CMD_LOCK)
				load_win_r <= `LOAD_WINDOW;
			else if (load_win_r != 2'h0)
				load_win_r <= load_win_r - 2'h1;
		end
	end

	// Load result for lock or fuse byte reads.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			load_result_valid <= 1'b0;
			load_result_data  <= 8'h00;
		end
		else if (clk_en)
		begin
			load_result_valid <= load_take;
			if (load_take)
				load_result_data <= address_pointer[0] ? fuse_low_bits : lock_bits;
		end
	end

	// Busy flag of the read-while-write section.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			rww_busy_r <= 1'b0;
		else if (spm_take)
		begin
			if ((cmd_r == self_program_flash_pkg::CMD_ERASE
				|| cmd_r == self_program_flash_pkg::CMD_WRITE)
				&& !write_locked && z_page < `NO_READ_WHILE_WRITE_SECTION_FIRST_PAGE)
				rww_busy_r <= 1'b1;
			else if (cmd_r == self_program_flash_pkg::CMD_FILL)
				rww_busy_r <= 1'b0;
			else if (cmd_r == self_program_flash_pkg::CMD_RWW)
				rww_busy_r <= 1'b0;
		end
	end

	// Core halt while the upper section is erased or written.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			halt_r <= 1'b0;
		else if (clk_en)
		begin
			if (spm_take && (cmd_r == self_program_flash_pkg::CMD_ERASE
				|| cmd_r == self_program_flash_pkg::CMD_WRITE)
				&& !write_locked && z_page >= `NO_READ_WHILE_WRITE_SECTION_FIRST_PAGE)
				halt_r <= 1'b1;
			else if (state_r == self_program_flash_pkg::ST_BUSY && flash_done)
				halt_r <= 1'b0;
		end
	end

	// Buffer load tracking and discard on a re-enable write.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			buf_dirty_r <= 1'b0;
			buf_discard <= 1'b0;
		end
		else if (clk_en)
		begin
			buf_discard <= wr_csr && pwdata[`BIT_RWW_REENABLE] && buf_dirty_r;
			if (spm_take && cmd_r == self_program_flash_pkg::CMD_FILL)
				buf_dirty_r <= 1'b1;
			else if (wr_csr && pwdata[`BIT_RWW_REENABLE])
				buf_dirty_r <= 1'b0;
			else if (state_r == self_program_flash_pkg::ST_BUSY && flash_done
				&& cmd_r == self_program_flash_pkg::CMD_WRITE)
				buf_dirty_r <= 1'b0;
		end
	end

	// Strobes to the flash array and the buffer.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			buf_wr_en        <= 1'b0;
			buf_wr_word      <= 6'h00;
			buf_wr_data      <= 16'h0000;
			page_erase_start <= 1'b0;
			page_write_start <= 1'b0;
			flash_page       <= 7'h00;
		end
		else if (clk_en)
		begin
			buf_wr_en        <= spm_take && cmd_r == self_program_flash_pkg::CMD_FILL;
			page_erase_start <= spm_take && cmd_r == self_program_flash_pkg::CMD_ERASE
				&& !write_locked;
			page_write_start <= spm_take && cmd_r == self_program_flash_pkg::CMD_WRITE
				&& !write_locked;
			if (spm_take && cmd_r == self_program_flash_pkg::CMD_FILL)
			begin
				buf_wr_word <= address_pointer[6:1];
				buf_wr_data <= {data_high_register, data_low_register};
			end
			if (spm_take)
				flash_page <= z_page;
		end
	end

	// Lock byte programming; a bit can only go from one to zero.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			lock_prog_valid <= 1'b0;
			lock_prog_data  <= 8'hFF;
		end
		else if (clk_en)
		begin
			lock_prog_valid <= spm_take && cmd_r == self_program_flash_pkg::CMD_LOCK;
			if (spm_take && cmd_r == self_program_flash_pkg::CMD_LOCK)
				lock_prog_data <= lock_bits & data_low_register;
		end
	end

	// Store-ready interrupt enable.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			irq_en_r <= 1'b0;
		else if (wr_csr)
			irq_en_r <= pwdata[`BIT_IRQ_EN];
	end

	// Sticky flag for a store refused by the section locks.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			rejected_r <= 1'b0;
		else if (spm_take && write_locked && (cmd_r == self_program_flash_pkg::CMD_ERASE
			|| cmd_r == self_program_flash_pkg::CMD_WRITE))
			rejected_r <= 1'b1;
		else if (wr_status && pwdata[`BIT_REJECTED])
			rejected_r <= 1'b0;
	end

	// Live view of the control and status bits.
	always_comb
	begin
		csr_view = `CSR_RESET;
		csr_view[`BIT_IRQ_EN]       = irq_en_r;
		csr_view[`BIT_RWW_BUSY]     = rww_busy_r;
		csr_view[`BIT_RWW_REENABLE] = (cmd_r == self_program_flash_pkg::CMD_RWW);
		csr_view[`BIT_LOCK_SET]     = (cmd_r == self_program_flash_pkg::CMD_LOCK);
		csr_view[`BIT_PAGE_WRITE]   = (cmd_r == self_program_flash_pkg::CMD_WRITE);
		csr_view[`BIT_PAGE_ERASE]   = (cmd_r == self_program_flash_pkg::CMD_ERASE);
		csr_view[`BIT_STORE_EN]     = store_en;
	end

	// Read data is loaded in the setup phase and holds through the access phase.
	// Loading it one cycle early lets pready stay high with no wait state.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			prdata <= 32'h00000000;
		else if (clk_en && psel && !penable)
		begin
			if (paddr == `CSR_OFFSET)
				prdata <= {24'h000000, csr_view};
			else if (paddr == `STATUS_OFFSET)
				prdata <= {23'h000000, rejected_r, lock_bits};
			else
				prdata <= 32'h00000000;
		end
	end

	// Every access completes in its first access cycle.
	assign pready  = 1'b1;
	assign pslverr = psel && penable && !mapped;

	// Busy, halt and interrupt outputs, and protection outputs decoded from the lock byte.
	assign rww_read_block   = rww_busy_r;
	assign cpu_halt         = halt_r;
	assign store_ready_irq  = irq_en_r && global_irq_enable && !store_en;
	assign ext_prog_block   = !lock_bits[`LOCK_MEM_LO];
	assign fuse_locked      = !lock_bits[`LOCK_MEM_LO];
	assign ext_verify_block = !lock_bits[`LOCK_MEM_LO] && !lock_bits[`LOCK_MEM_HI];
	assign boot_lock_locked = !lock_bits[`LOCK_MEM_LO] && !lock_bits[`LOCK_MEM_HI];
	assign app_read_deny    = !lock_bits[`LOCK_APP_HI] && pc_in_boot && !z_boot;
	assign app_irq_block    = !lock_bits[`LOCK_APP_HI] && irq_vectors_in_boot
		&& !pc_in_boot;
	assign boot_read_deny   = !lock_bits[`LOCK_BOOT_HI] && !pc_in_boot && z_boot;
	assign boot_irq_block   = !lock_bits[`LOCK_BOOT_HI] && !irq_vectors_in_boot && pc_in_boot;

endmodule : self_program_flash_control

// ===== design/self_program_flash_map.svh
`ifndef SELF_PROGRAM_FLASH_MAP_SVH
`define SELF_PROGRAM_FLASH_MAP_SVH

`define CSR_OFFSET        12'h000
`define STATUS_OFFSET     12'h004
`define CSR_RESET         8'h00
`define CMD_CODE_FILL     5'h01
`define CMD_CODE_ERASE    5'h03
`define CMD_CODE_WRITE    5'h05
`define CMD_CODE_LOCK     5'h09
`define CMD_CODE_RWW      5'h11
`define BIT_IRQ_EN        7
`define BIT_RWW_BUSY      6
`define BIT_RWW_REENABLE  4
`define BIT_LOCK_SET      3
`define BIT_PAGE_WRITE    2
`define BIT_PAGE_ERASE    1
`define BIT_STORE_EN      0
`define BIT_REJECTED      8
`define STORE_WINDOW      3'h4
`define LOAD_WINDOW       2'h3
`define NO_READ_WHILE_WRITE_SECTION_FIRST_PAGE   7'h70
`define LOCK_BOOT_HI      5
`define LOCK_BOOT_LO      4
`define LOCK_APP_HI       3
`define LOCK_APP_LO       2
`define LOCK_MEM_HI       1
`define LOCK_MEM_LO       0

`endif

// ===== design/self_program_flash_pkg.sv
package self_program_flash_pkg;

	typedef enum logic [2:0] {
		ST_IDLE  = 3'b001,
		ST_ARMED = 3'b010,
		ST_BUSY  = 3'b100
	} state_t;

	typedef enum logic [2:0] {
		CMD_NONE  = 3'h0,
		CMD_FILL  = 3'h1,
		CMD_ERASE = 3'h2,
		CMD_WRITE = 3'h3,
		CMD_LOCK  = 3'h4,
		CMD_RWW   = 3'h5
	} cmd_t;

endpackage : self_program_flash_pkg

// ===== tb/flash_array_model.sv
`timescale 1ns/1ns

module flash_array_model
(
	// Clock and reset.
	input  wire logic       pclk,
	input  wire logic       presetn,
	// Operation start and its length in cycles.
	input  wire logic       start,
	input  wire logic [7:0] busy_cycles,
	// Completion strobe.
	output logic            flash_done
);
	logic [7:0] count_r;

	// The array counts down the operation and strobes done for one cycle.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			count_r    <= 8'h00;
			flash_done <= 1'b0;
		end
		else
		begin
			flash_done <= (count_r == 8'h01);
			if (start)
				count_r <= busy_cycles;
			else if (count_r != 8'h00)
				count_r <= count_r - 8'h01;
		end
	end
endmodule : flash_array_model

// ===== tb/self_program_flash_control_assertions.sv
`timescale 1ns/1ns
`include "self_program_flash_map.svh"

module self_program_flash_control_assertions
(
	// Clock and reset.
	input wire logic        pclk,
	input wire logic        presetn,
	// Core side.
	input wire logic        store_program_instr,
	input wire logic        load_program_instr,
	input wire logic [15:0] address_pointer,
	input wire logic [7:0]  data_low_register,
	input wire logic [7:0]  data_high_register,
	input wire logic        pc_in_boot,
	input wire logic        load_result_valid,
	input wire logic        cpu_halt,
	input wire logic        app_read_deny,
	// Lock side.
	input wire logic [7:0]  lock_bits,
	input wire logic [6:0]  boot_start_page,
	input wire logic        lock_prog_valid,
	input wire logic [7:0]  lock_prog_data,
	input wire logic        ext_prog_block,
	input wire logic        ext_verify_block,
	// Flash side.
	input wire logic        flash_done,
	input wire logic        buf_wr_en,
	input wire logic [15:0] buf_wr_data,
	input wire logic        page_erase_start,
	input wire logic        page_write_start,
	input wire logic [6:0]  flash_page,
	input wire logic        rww_read_block
);
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	sequence s_start;
		page_erase_start || page_write_start;
	endsequence
	sequence s_no_read_while_write_section;
		s_start ##0 (flash_page >= `NO_READ_WHILE_WRITE_SECTION_FIRST_PAGE);
	endsequence
	sequence s_rww;
		s_start ##0 (flash_page < `NO_READ_WHILE_WRITE_SECTION_FIRST_PAGE);
	endsequence

	property p_fill; buf_wr_en |-> buf_wr_data == $past({data_high_register, data_low_register}); endproperty
	a_fill: assert property (p_fill) else $error("fill word wrong");
	property p_start; s_start |-> $past(store_program_instr); endproperty
	a_start: assert property (p_start) else $error("start without store");
	property p_page; s_start |-> flash_page == $past(address_pointer[13:7]); endproperty
	a_page: assert property (p_page) else $error("page wrong");
	property p_halt; s_no_read_while_write_section |-> cpu_halt; endproperty
	a_halt: assert property (p_halt) else $error("core not halted");
	property p_halt_end; cpu_halt && flash_done |=> !cpu_halt; endproperty
	a_halt_end: assert property (p_halt_end) else $error("halt stuck");
	property p_rww; s_rww |-> rww_read_block; endproperty
	a_rww: assert property (p_rww) else $error("reads not blocked");
	property p_lock; lock_prog_valid |-> lock_prog_data == ($past(lock_bits) & $past(data_low_register)); endproperty
	a_lock: assert property (p_lock) else $error("lock data wrong");
	property p_load; load_result_valid |-> $past(load_program_instr); endproperty
	a_load: assert property (p_load) else $error("load without instruction");
	property p_ext; ext_prog_block == !lock_bits[0] && ext_verify_block == (!lock_bits[0] && !lock_bits[1]); endproperty
	a_ext: assert property (p_ext) else $error("external block wrong");
	property p_deny; app_read_deny == (!lock_bits[3] && pc_in_boot && address_pointer[13:7] < boot_start_page); endproperty
	a_deny: assert property (p_deny) else $error("read deny wrong");
endmodule : self_program_flash_control_assertions

// ===== tb/self_program_flash_control_tb_top.sv
`timescale 1ns/1ns
`include "self_program_flash_map.svh"

module self_program_flash_control_tb_top;
	logic        pclk = 1'b0;
	logic        presetn = 1'b0;
	logic        clk_en = 1'b1;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic        store_program_instr = 1'b0;
	logic        load_program_instr = 1'b0;
	logic [15:0] address_pointer = 16'h0000;
	logic [7:0]  data_low_register = 8'h00;
	logic [7:0]  data_high_register = 8'h00;
	logic        pc_in_boot = 1'b0;
	logic        irq_vectors_in_boot = 1'b0;
	logic        global_irq_enable = 1'b1;
	logic [7:0]  lock_bits = 8'hFF;
	logic [7:0]  fuse_low_bits = 8'h5A;
	logic [6:0]  boot_start_page = 7'h70;
	logic [7:0]  busy_cycles = 8'h14;
	logic [31:0] prdata, rd, last_wr = 32'h0, last_page = 32'h0, last_lock = 32'h0, last_load = 32'h0;
	logic        pready, pslverr, err, flash_done, load_result_valid, cpu_halt, store_ready_irq;
	logic        app_read_deny, lock_prog_valid, ext_prog_block, ext_verify_block, buf_wr_en;
	logic        buf_discard, page_erase_start, page_write_start, rww_read_block;
	logic        boot_read_deny, app_irq_block, boot_irq_block, fuse_locked, boot_lock_locked;
	logic [3:0]  deny_got, deny_exp;
	logic [7:0]  load_result_data, lock_prog_data;
	logic [5:0]  buf_wr_word;
	logic [15:0] buf_wr_data;
	logic [6:0]  flash_page;
	int          fail_count = 0;
	int          checks_done = 0;
	int          cycles = 0;
	int          n_disc = 0;
	int          n_start = 0;

	self_program_flash_control self_program_flash_control_inst
	(
		.pclk, .presetn, .clk_en, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
		.pready, .pslverr, .store_program_instr, .load_program_instr, .address_pointer,
		.data_low_register, .data_high_register, .pc_in_boot, .irq_vectors_in_boot,
		.global_irq_enable, .load_result_valid, .load_result_data, .cpu_halt,
		.store_ready_irq, .app_read_deny, .boot_read_deny, .app_irq_block,
		.boot_irq_block, .lock_bits, .fuse_low_bits, .boot_start_page,
		.lock_prog_valid, .lock_prog_data, .ext_prog_block, .ext_verify_block,
		.fuse_locked, .boot_lock_locked, .flash_done, .buf_wr_en, .buf_wr_word,
		.buf_wr_data, .buf_discard, .page_erase_start, .page_write_start, .flash_page,
		.rww_read_block
	);

	flash_array_model flash_array_model_inst
	(
		.pclk, .presetn, .start(page_erase_start | page_write_start), .busy_cycles, .flash_done
	);

	always #50 pclk = ~pclk;

	// Records the pulses of the design and cuts a hang short.
	always @(posedge pclk)
	begin
		cycles <= cycles + 1;
		if (buf_wr_en === 1'b1)
			last_wr <= {10'h000, buf_wr_word, buf_wr_data};
		if (buf_discard === 1'b1)
			n_disc <= n_disc + 1;
		if ((page_erase_start | page_write_start) === 1'b1)
		begin
			n_start <= n_start + 1;
			last_page <= {25'h0, flash_page};
		end
		if (lock_prog_valid === 1'b1)
			last_lock <= {24'h0, lock_prog_data};
		if (load_result_valid === 1'b1)
			last_load <= {24'h0, load_result_data};
		if (cycles == 20000)
		begin
			fail_count++;
			end_sim();
		end
	end

	task automatic end_sim;
		$display("Checks %0d, mismatches %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : end_sim

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp)
		begin
			fail_count++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= wr;
		paddr   <= a;
		pwdata  <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do
			@(posedge pclk);
		while (pready !== 1'b1);
		rd      = prdata;
		err     = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask : apb

	task automatic cmd(input logic [7:0] c, input logic ld, input logic [15:0] p,
		input logic [15:0] d);
		apb(1'b1, `CSR_OFFSET, {24'h000000, c});
		address_pointer     <= p;
		data_high_register  <= d[15:8];
		data_low_register   <= d[7:0];
		store_program_instr <= !ld;
		load_program_instr  <= ld;
		@(posedge pclk);
		store_program_instr <= 1'b0;
		load_program_instr  <= 1'b0;
		repeat (3) @(posedge pclk);
	endtask : cmd

	task automatic wait_idle;
		do
			apb(1'b0, `CSR_OFFSET, 32'h0);
		while (rd[`BIT_STORE_EN] !== 1'b0);
	endtask : wait_idle

	initial
	begin
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		apb(1'b0, `CSR_OFFSET, 32'h0);
		chk(rd, 32'h0);
		apb(1'b0, `STATUS_OFFSET, 32'h0);
		chk(rd, 32'hFF);
		apb(1'b1, 12'h008, 32'hFF);
		apb(1'b0, 12'h008, 32'h0);
		chk({rd[30:0], err}, 32'h1);
		$display("Test reset done");
		apb(1'b1, `CSR_OFFSET, 32'h87);
		apb(1'b0, `CSR_OFFSET, 32'h0);
		chk(rd, 32'h80);
		chk({31'h0, store_ready_irq}, 32'h1);
		cmd(8'h81, 1'b0, 16'h0083, 16'hA53C);
		chk(last_wr, 32'h0001A53C);
		apb(1'b0, `CSR_OFFSET, 32'h0);
		chk(rd, 32'h80);
		apb(1'b1, `CSR_OFFSET, 32'h11);
		repeat (5) @(posedge pclk);
		chk(32'(n_disc), 32'h1);
		apb(1'b1, `CSR_OFFSET, 32'h05);
		repeat (5) @(posedge pclk);
		apb(1'b0, `CSR_OFFSET, 32'h0);
		chk(rd, 32'h0);
		chk(32'(n_start), 32'h0);
		$display("Test fill and timeout done");
		cmd(8'h05, 1'b0, 16'h0280, 16'h0);
		chk(last_page, 32'h05);
		chk({31'h0, rww_read_block}, 32'h1);
		apb(1'b1, `CSR_OFFSET, 32'h11);
		apb(1'b0, `CSR_OFFSET, 32'h0);
		chk(rd, 32'h45);
		wait_idle();
		chk(rd, 32'h40);
		cmd(8'h11, 1'b0, 16'h0, 16'h0);
		apb(1'b0, `CSR_OFFSET, 32'h0);
		chk(rd, 32'h0);
		for (int i = 0; i < 2; i++)
		begin
			busy_cycles <= i ? 8'h06 : 8'h28;
			cmd(8'h03, 1'b0, i ? 16'h3900 : 16'h0300, 16'h0);
			chk(last_page, i ? 32'h72 : 32'h06);
			chk({30'h0, cpu_halt, rww_read_block}, i ? 32'h2 : 32'h1);
			wait_idle();
			chk({31'h0, cpu_halt}, 32'h0);
			cmd(8'h01, 1'b0, 16'h0, 16'h0);
			apb(1'b0, `CSR_OFFSET, 32'h0);
			chk(rd, 32'h0);
		end
		$display("Test page write and erase done");
		cmd(8'h09, 1'b0, 16'h0, 16'h00F3);
		chk(last_lock, 32'hF3);
		apb(1'b0, `CSR_OFFSET, 32'h0);
		chk(rd, 32'h0);
		for (int i = 0; i < 2; i++)
		begin
			cmd(8'h09, 1'b1, i ? 16'h0001 : 16'h0000, 16'h0);
			chk(last_load, i ? 32'h5A : 32'hFF);
		end
		pc_in_boot <= 1'b1;
		for (int i = 0; i < 2; i++)
		begin
			lock_bits <= i ? 8'hEC : 8'hFA;
			cmd(8'h05, 1'b0, i ? 16'h3900 : 16'h0280, 16'h0);
			chk(32'(n_start), 32'h3);
			apb(1'b0, `STATUS_OFFSET, 32'h0);
			chk(rd, i ? 32'h1EC : 32'h1FA);
			chk({31'h0, ext_verify_block}, 32'(i));
			chk({30'h0, fuse_locked, boot_lock_locked}, i ? 32'h3 : 32'h2);
			apb(1'b1, `STATUS_OFFSET, 32'h100);
		end
		$display("Test lock bits done");
		lock_bits <= 8'hD7;
		for (int i = 0; i < 4; i++)
		begin
			pc_in_boot          <= i[0];
			irq_vectors_in_boot <= i[1];
			address_pointer     <= i[0] ? 16'h0280 : 16'h3900;
			@(posedge pclk);
			deny_got = {app_read_deny, boot_read_deny, app_irq_block, boot_irq_block};
			deny_exp = (i == 0) ? 4'h4 : (i == 1) ? 4'h9 : (i == 2) ? 4'h6 : 4'h8;
			chk({28'h0, deny_got}, {28'h0, deny_exp});
		end
		$display("Test section access done");
		lock_bits <= 8'hFF;
		cmd(8'h85, 1'b0, 16'h3900, 16'h0);
		chk({30'h0, cpu_halt, rww_read_block}, 32'h2);
		presetn <= 1'b0;
		@(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		apb(1'b0, `CSR_OFFSET, 32'h0);
		chk(rd, 32'h0);
		chk({30'h0, cpu_halt, rww_read_block}, 32'h0);
		$display("Test reset in operation done");
		end_sim();
	end
endmodule : self_program_flash_control_tb_top

bind self_program_flash_control self_program_flash_control_assertions sva_inst
(
	.pclk, .presetn, .store_program_instr, .load_program_instr, .address_pointer,
	.data_low_register, .data_high_register, .pc_in_boot, .load_result_valid, .cpu_halt,
	.app_read_deny, .lock_bits, .boot_start_page, .lock_prog_valid, .lock_prog_data,
	.ext_prog_block, .ext_verify_block, .flash_done, .buf_wr_en, .buf_wr_data,
	.page_erase_start, .page_write_start, .flash_page, .rww_read_block
);
